// ===== i2c_paged_slave.sv
`timescale 1ns/100ps

// Operation
// - Address byte first, MSB first
// - Clock input only, data open-drain
// - Data changes only while clock low
// - START/STOP: data edge, clock high
// - Eight bits plus released acknowledge bit
// - Receiver acks low during ack high
// - On read nack, release line high
// - ACh write, ADh read
// - Seven-bit address plus direction bit
// - Pointer byte: page high, word low
// - Advance word after each good byte
// - No advance without acknowledge
// - Snapshot registers into cache at START
// - Cache frozen until STOP or a repeated START, which takes a new snapshot
// - STOP after write copies modified back
// - Set pointer, STOP, then read there
// - Plain read starts past last write, or at the last byte read
// - Unlimited bytes per transfer
module i2c_paged_slave (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   // Serial link
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe_n_out,
   // Live register read port
   output logic      [7:0] live_raddr_out,
   input  wire logic [7:0] live_rdata_in,
   // Live register write port
   output logic            live_wvalid_out,
   input  wire logic       live_wready_in,
   output logic      [7:0] live_waddr_out,
   output logic      [7:0] live_wdata_out,
   // Status
   output logic            xfer_active_out,
   output logic            cache_busy_out
);

   // ==========================================================
   // State
   typedef struct packed {
      i2c_pkg::bus_state_e                     st;
      i2c_pkg::bus_state_e                     nxt;
      logic [3:0]                              bcnt;
      logic [7:0]                              shift;
      logic [7:0]                              tx;
      logic                                    sda_low;
      logic [7:0]                              ptr;
      logic                                    wrote;
      logic                                    scl_p;
      logic                                    sda_p;
      i2c_pkg::cache_state_e                   cst;
      logic [4:0]                              ccnt;
      logic                                    snap_req;
      logic                                    flush_req;
      logic [7:0]                              raddr;
      logic                                    load_pend;
      logic                                    wpend;
      logic [7:0]                              waddr;
      logic [7:0]                              wdata;
      logic [i2c_pkg::CACHE_WORDS-1:0]         dirty;
      logic [i2c_pkg::CACHE_WORDS-1:0][7:0]    cache;
   } slave_s;

   slave_s s_q;
   slave_s s_d;

   // ==========================================================
   // Helpers
   function automatic logic page_cached(input logic [7:0] p);
      page_cached = (p[7:3] >= i2c_pkg::CPAGE_LO) && (p[7:3] <= i2c_pkg::CPAGE_HI);
   endfunction

   function automatic logic [4:0] cache_idx(input logic [7:0] p);
      logic [4:0] rel;
      rel       = p[7:3] - i2c_pkg::CPAGE_LO;
      cache_idx = {rel[1:0], p[2:0]};
   endfunction

   function automatic logic [7:0] cache_addr(input logic [4:0] i);
      logic [4:0] pg;
      pg         = i2c_pkg::CPAGE_LO + {3'h0, i[4:3]};
      cache_addr = {pg, i[2:0]};
   endfunction

   // Page bits are kept, so the word part wraps to zero
   function automatic logic [7:0] ptr_inc(input logic [7:0] p);
      ptr_inc = {p[7:3], p[2:0] + 3'h1};
   endfunction

   // ==========================================================
   // Line synchronisers
   logic [1:0] lines;
   logic       scl;
   logic       sda;

   pin_sync #(
      .W       (2),
      .RST_VAL (i2c_pkg::LINE_IDLE)
   ) u_sync (
      .clk_in   (clk_in),
      .rstn_in  (rstn_in),
      .async_in ({scl_in, sda_in}),
      .sync_out (lines)
   );

   assign scl = lines[1];
   assign sda = lines[0];

   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;

   assign scl_rise  = scl && !s_q.scl_p;
   assign scl_fall  = !scl && s_q.scl_p;
   assign start_det = scl && s_q.scl_p && s_q.sda_p && !sda;
   assign stop_det  = scl && s_q.scl_p && !s_q.sda_p && sda;

   // ==========================================================
   // Write-back buffer
   logic        buf_in_valid;
   logic        buf_in_ready;
   logic [15:0] buf_in_data;
   logic [15:0] buf_out_data;
   logic        flush_push;

   assign flush_push   = (s_q.cst == i2c_pkg::C_FLUSH) && s_q.dirty[s_q.ccnt] && !s_q.wpend;
   assign buf_in_valid = s_q.wpend || flush_push;
   assign buf_in_data  = s_q.wpend ? {s_q.waddr, s_q.wdata}
                                   : {cache_addr(s_q.ccnt), s_q.cache[s_q.ccnt]};

   word_buffer #(
      .W     (i2c_pkg::BUF_W),
      .DEPTH (i2c_pkg::BUF_DEPTH)
   ) u_buf (
      .clk_in        (clk_in),
      .rstn_in       (rstn_in),
      .in_valid_in   (buf_in_valid),
      .in_ready_out  (buf_in_ready),
      .in_data_in    (buf_in_data),
      .out_valid_out (live_wvalid_out),
      .out_ready_in  (live_wready_in),
      .out_data_out  (buf_out_data)
   );

   assign live_waddr_out = buf_out_data[15:8];
   assign live_wdata_out = buf_out_data[7:0];

   // ==========================================================
   // Next state
   logic       load_now;
   logic [7:0] load_ptr;

   always_comb begin
      s_d      = s_q;
      load_now = 1'b0;
      load_ptr = s_q.ptr;

      s_d.scl_p = scl;
      s_d.sda_p = sda;

      if (s_q.load_pend) begin
         s_d.tx        = live_rdata_in;
         s_d.load_pend = 1'b0;
      end

      if (s_q.wpend && buf_in_ready) begin
         s_d.wpend = 1'b0;
      end

      // Cache sequencer: a pending flush is queued into the write-back buffer before a new
      // snapshot, but the snapshot does not wait for the buffer to drain to the live registers
      case (s_q.cst)
         i2c_pkg::C_IDLE: begin
            if (s_q.flush_req) begin
               s_d.flush_req = 1'b0;
               s_d.cst       = i2c_pkg::C_FLUSH;
               s_d.ccnt      = '0;
            end else if (s_q.snap_req) begin
               s_d.snap_req = 1'b0;
               s_d.cst      = i2c_pkg::C_SNAP;
               s_d.ccnt     = '0;
               s_d.raddr    = cache_addr(5'h00);
            end
         end
         i2c_pkg::C_SNAP: begin
            s_d.cache[s_q.ccnt] = live_rdata_in;
            s_d.dirty[s_q.ccnt] = 1'b0;
            if (s_q.ccnt == i2c_pkg::CACHE_LAST) begin
               s_d.cst = i2c_pkg::C_IDLE;
            end else begin
               s_d.ccnt  = s_q.ccnt + 5'h01;
               s_d.raddr = cache_addr(s_q.ccnt + 5'h01);
            end
         end
         i2c_pkg::C_FLUSH: begin
            if (!s_q.wpend && (!s_q.dirty[s_q.ccnt] || buf_in_ready)) begin
               s_d.dirty[s_q.ccnt] = 1'b0;
               if (s_q.ccnt == i2c_pkg::CACHE_LAST) begin
                  s_d.cst = i2c_pkg::C_IDLE;
               end else begin
                  s_d.ccnt = s_q.ccnt + 5'h01;
               end
            end
         end
         default: begin
            s_d.cst = i2c_pkg::C_IDLE;
         end
      endcase

      // Bus protocol; a START restarts from any state
      if (start_det) begin
         s_d.st       = i2c_pkg::B_ADDR;
         s_d.bcnt     = '0;
         s_d.sda_low  = 1'b0;
         s_d.wrote    = 1'b0;
         s_d.snap_req = 1'b1;
      end else if (stop_det) begin
         s_d.st      = i2c_pkg::B_IDLE;
         s_d.sda_low = 1'b0;
         if (s_q.wrote) begin
            s_d.flush_req = 1'b1;
         end
      end else begin
         case (s_q.st)
            i2c_pkg::B_ADDR, i2c_pkg::B_PTR, i2c_pkg::B_WDATA: begin
               if (scl_rise && s_q.bcnt != i2c_pkg::BYTE_BITS) begin
                  s_d.shift = {s_q.shift[6:0], sda};
                  s_d.bcnt  = s_q.bcnt + 4'h1;
               end else if (scl_fall && s_q.bcnt == i2c_pkg::BYTE_BITS) begin
                  s_d.bcnt    = '0;
                  s_d.st      = i2c_pkg::B_ACK;
                  s_d.sda_low = 1'b1;
                  if (s_q.st == i2c_pkg::B_ADDR) begin
                     if (s_q.shift[7:1] == i2c_pkg::SLAVE_ADDR7) begin
                        if (s_q.shift[0]) begin
                           s_d.nxt  = i2c_pkg::B_RDATA;
                           load_now = 1'b1;
                        end else begin
                           s_d.nxt = i2c_pkg::B_PTR;
                        end
                     end else begin
                        s_d.st      = i2c_pkg::B_IGNORE;
                        s_d.sda_low = 1'b0;
                     end
                  end else if (s_q.st == i2c_pkg::B_PTR) begin
                     s_d.ptr = s_q.shift;
                     s_d.nxt = i2c_pkg::B_WDATA;
                  end else begin
                     s_d.nxt   = i2c_pkg::B_WDATA;
                     s_d.ptr   = ptr_inc(s_q.ptr);
                     s_d.wrote = 1'b1;
                     if (page_cached(s_q.ptr)) begin
                        s_d.cache[cache_idx(s_q.ptr)] = s_q.shift;
                        s_d.dirty[cache_idx(s_q.ptr)] = 1'b1;
                     end else begin
                        s_d.wpend = 1'b1;
                        s_d.waddr = s_q.ptr;
                        s_d.wdata = s_q.shift;
                     end
                  end
               end
            end
            i2c_pkg::B_ACK: begin
               if (scl_fall) begin
                  s_d.st      = s_q.nxt;
                  s_d.bcnt    = '0;
                  s_d.sda_low = (s_q.nxt == i2c_pkg::B_RDATA) ? !s_q.tx[7] : 1'b0;
               end
            end
            i2c_pkg::B_RDATA: begin
               if (scl_fall) begin
                  if (s_q.bcnt == i2c_pkg::LAST_BIT) begin
                     s_d.st      = i2c_pkg::B_RDACK;
                     s_d.sda_low = 1'b0;
                     s_d.bcnt    = '0;
                  end else begin
                     s_d.tx      = {s_q.tx[6:0], 1'b0};
                     s_d.sda_low = !s_q.tx[6];
                     s_d.bcnt    = s_q.bcnt + 4'h1;
                  end
               end
            end
            i2c_pkg::B_RDACK: begin
               if (scl_rise) begin
                  if (!sda) begin
                     s_d.ptr  = ptr_inc(s_q.ptr);
                     load_now = 1'b1;
                     load_ptr = ptr_inc(s_q.ptr);
                     s_d.st   = i2c_pkg::B_ACK;
                     s_d.nxt  = i2c_pkg::B_RDATA;
                  end else begin
                     s_d.st = i2c_pkg::B_IGNORE;
                  end
               end
            end
            i2c_pkg::B_IDLE, i2c_pkg::B_IGNORE: begin
               s_d.sda_low = 1'b0;
            end
            default: begin
               s_d.st      = i2c_pkg::B_IDLE;
               s_d.sda_low = 1'b0;
            end
         endcase
      end

      // Fetch the byte to transmit; uncached pages take one extra cycle
      if (load_now) begin
         if (page_cached(load_ptr)) begin
            s_d.tx = s_q.cache[cache_idx(load_ptr)];
         end else begin
            s_d.raddr     = load_ptr;
            s_d.load_pend = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s_q       <= '0;
         s_q.ptr   <= i2c_pkg::PTR_RST;
         // Idle line level, so no false edge is seen just after reset
         s_q.scl_p <= i2c_pkg::LINE_IDLE[1];
         s_q.sda_p <= i2c_pkg::LINE_IDLE[0];
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // Outputs
   // The line is only ever pulled low; the pull-up makes the high level
   assign sda_out         = 1'b0;
   assign sda_oe_n_out    = !s_q.sda_low;
   assign live_raddr_out  = s_q.raddr;
   assign xfer_active_out = (s_q.st != i2c_pkg::B_IDLE) && (s_q.st != i2c_pkg::B_IGNORE);
   assign cache_busy_out  = (s_q.cst != i2c_pkg::C_IDLE);

endmodule

// ===== i2c_pkg.sv
package i2c_pkg;

   // ==========================================================
   // Addressing
   localparam logic [6:0] SLAVE_ADDR7 = 7'h56;
   localparam logic [7:0] ADDR_WR     = 8'hAC;
   localparam logic [7:0] ADDR_RD     = 8'hAD;
   localparam logic [3:0] BYTE_BITS   = 4'h8;
   localparam logic [3:0] LAST_BIT    = 4'h7;
   localparam logic [7:0] PTR_RST     = 8'h00;

   // ==========================================================
   // Cache layout: four consecutive pages of eight words each
   localparam logic [4:0] CPAGE_LO    = 5'h01;
   localparam logic [4:0] CPAGE_HI    = 5'h04;
   localparam int         CACHE_WORDS = 32;
   localparam logic [4:0] CACHE_LAST  = 5'h1F;

   // ==========================================================
   // Link pins and write-back buffer
   localparam logic [1:0] LINE_IDLE   = 2'h3;
   localparam int         BUF_W       = 16;
   localparam int         BUF_DEPTH   = 2;

   // ==========================================================
   // State encodings
   typedef enum logic [2:0] {
      B_IDLE,
      B_ADDR,
      B_PTR,
      B_WDATA,
      B_ACK,
      B_RDATA,
      B_RDACK,
      B_IGNORE
   } bus_state_e;

   typedef enum logic [1:0] {
      C_IDLE,
      C_SNAP,
      C_FLUSH
   } cache_state_e;

endpackage

// ===== pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
   parameter int         W       = 2,
   parameter logic [W-1:0] RST_VAL = '1
) (
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         rstn_in,
   // Lines
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_s;

   sync_s s_q;
   sync_s s_d;

   always_comb begin
      s_d    = s_q;
      s_d.s1 = async_in;
      s_d.s2 = s_q.s1;
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s_q <= {RST_VAL, RST_VAL};
      end else begin
         s_q <= s_d;
      end
   end

   assign sync_out = s_q.s2;

endmodule

// ===== word_buffer.sv
`timescale 1ns/100ps
module word_buffer #(
   parameter int W     = 16,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         rstn_in,
   // Fill side
   input  wire logic         in_valid_in,
   output logic              in_ready_out,
   input  wire logic [W-1:0] in_data_in,
   // Drain side
   output logic              out_valid_out,
   input  wire logic         out_ready_in,
   output logic      [W-1:0] out_data_out
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wr;
      logic [AW-1:0]           rd;
      logic [CW-1:0]           cnt;
   } buf_s;

   buf_s s_q;
   buf_s s_d;
   logic push;
   logic pop;

   assign in_ready_out  = (s_q.cnt != CW'(DEPTH));
   assign out_valid_out = (s_q.cnt != '0);
   assign out_data_out  = s_q.mem[s_q.rd];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.mem[s_q.wr] = in_data_in;
         s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + AW'(1);
      end
      if (pop) begin
         s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + AW'(1);
      end
      if (push && !pop) begin
         s_d.cnt = s_q.cnt + CW'(1);
      end else if (pop && !push) begin
         s_d.cnt = s_q.cnt - CW'(1);
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule

// ===== i2c_paged_slave_assertions.sv
`timescale 1ns/100ps
// ======================================
// Port checks of the paged serial slave
module i2c_paged_slave_assertions (
   // Clock and reset
   input wire logic       clk_in,
   input wire logic       rstn_in,
   // Serial link
   input wire logic       scl_in,
   input wire logic       sda_in,
   input wire logic       sda_out,
   input wire logic       sda_oe_n_out,
   // Live ports
   input wire logic [7:0] live_raddr_out,
   input wire logic [7:0] live_rdata_in,
   input wire logic       live_wvalid_out,
   input wire logic       live_wready_in,
   input wire logic [7:0] live_waddr_out,
   input wire logic [7:0] live_wdata_out,
   // Status
   input wire logic       xfer_active_out,
   input wire logic       cache_busy_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rstn_in);

   a_sda_zero: assert property (sda_out == 1'b0)
      else $error("data drive value not zero");
   a_reset_quiet: assert property (disable iff (1'b0) !rstn_in |-> sda_oe_n_out
      && !live_wvalid_out && !xfer_active_out && !cache_busy_out)
      else $error("outputs active during reset");
   // Drive may only move while the clock pin was low one edge before
   a_drive_scl_low: assert property ($changed(sda_oe_n_out) |-> !$past(scl_in))
      else $error("data drive changed while clock high");
   a_idle_release: assert property (!xfer_active_out |-> sda_oe_n_out)
      else $error("data line driven outside a transfer");
   a_ack_stands: assert property ($fell(sda_oe_n_out) |-> !sda_oe_n_out [*6])
      else $error("low drive shorter than a clock period");
   a_wb_hold: assert property (live_wvalid_out && !live_wready_in |=>
      live_wvalid_out && $stable(live_waddr_out) && $stable(live_wdata_out))
      else $error("write-back word lost or changed while stalled");
   a_snap_starts: assert property ($rose(xfer_active_out) |-> ##[0:2] cache_busy_out)
      else $error("no snapshot at start");
   a_snap_range: assert property (cache_busy_out && $past(cache_busy_out)
      && xfer_active_out |-> live_raddr_out inside {[8'h08:8'h27]})
      else $error("snapshot address outside cached pages");

   c_drive: cover property ($fell(sda_oe_n_out));
   c_stall: cover property (live_wvalid_out && !live_wready_in);
   c_start: cover property ($rose(xfer_active_out));
endmodule

bind i2c_paged_slave i2c_paged_slave_assertions chk (
   .clk_in          (clk_in),
   .rstn_in         (rstn_in),
   .scl_in          (scl_in),
   .sda_in          (sda_in),
   .sda_out         (sda_out),
   .sda_oe_n_out    (sda_oe_n_out),
   .live_raddr_out  (live_raddr_out),
   .live_rdata_in   (live_rdata_in),
   .live_wvalid_out (live_wvalid_out),
   .live_wready_in  (live_wready_in),
   .live_waddr_out  (live_waddr_out),
   .live_wdata_out  (live_wdata_out),
   .xfer_active_out (xfer_active_out),
   .cache_busy_out  (cache_busy_out)
);

// ===== i2c_master_model.sv
`timescale 1ns/100ps
// ======================================
// Bus master, 32 ns clock, open drain
module i2c_master_model (
   // Serial link
   output logic      scl_out,
   output logic      sda_pull_out,
   input  wire logic sda_in
);
   initial begin
      scl_out = 1'b1;
      sda_pull_out = 1'b0;
   end

   task automatic bit_io(input logic b, output logic r);
      #8 sda_pull_out = ~b;
      #8 scl_out = 1'b1;
      #8 r = sda_in;
      #8 scl_out = 1'b0;
   endtask

   // Odd offset keeps link edges off the system clock edges
   task automatic start();
      wait (scl_out && sda_in);
      #1.3 sda_pull_out = 1'b1;
      #8 scl_out = 1'b0;
   endtask

   task automatic stop();
      #8 sda_pull_out = 1'b1;
      #8 scl_out = 1'b1;
      #8 sda_pull_out = 1'b0;
      #8;
   endtask

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask

   task automatic rd_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(~ack, r);
   endtask
endmodule

// ===== i2c_paged_slave_bench.sv
`timescale 1ns/100ps
module i2c_paged_slave_bench;
   logic       clk_in = 1'b0;
   logic       rstn_in = 1'b1;
   logic       scl_in, m_pull, sda_out, sda_oe_n_out, live_wvalid_out;
   logic       live_wready_in = 1'b0;
   logic       xfer_active_out, cache_busy_out;
   logic       stall = 1'b0;
   logic [7:0] live_raddr_out, live_waddr_out, live_wdata_out, ptr;
   logic [7:0] live_mem [256];
   logic [7:0] exp_mem [256];
   logic [7:0] snap [8];
   int         fails = 0;
   int         n_checks = 0;
   wire logic  sda_in = (sda_oe_n_out ? 1'b1 : sda_out) & ~m_pull;
   wire logic [7:0] live_rdata_in = live_mem[live_raddr_out];

   always #2 clk_in = ~clk_in;
   always @(posedge clk_in)
      if (live_wvalid_out && live_wready_in) live_mem[live_waddr_out] <= live_wdata_out;
   always @(negedge clk_in)
      live_wready_in <= !stall && ($urandom_range(0, 2) != 0);

   i2c_paged_slave dut (
      .clk_in(clk_in), .rstn_in(rstn_in), .scl_in(scl_in), .sda_in(sda_in),
      .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .live_raddr_out(live_raddr_out),
      .live_rdata_in(live_rdata_in), .live_wvalid_out(live_wvalid_out),
      .live_wready_in(live_wready_in), .live_waddr_out(live_waddr_out),
      .live_wdata_out(live_wdata_out), .xfer_active_out(xfer_active_out),
      .cache_busy_out(cache_busy_out));
   i2c_master_model m (.scl_out(scl_in), .sda_pull_out(m_pull), .sda_in(sda_in));

   // ======================================
   // Checking helpers
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done();
      if (fails == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   function automatic logic [7:0] nxt(input logic [7:0] p);
      return {p[7:3], p[2:0] + 3'h1};
   endfunction

   // Write-back must drain before the next start, or the snapshot may read stale live words
   task automatic settle();
      int n = 0;
      repeat (6) @(negedge clk_in);
      while ((cache_busy_out || live_wvalid_out) && n < 3000) begin
         @(negedge clk_in);
         n++;
         if (n == 200) stall <= 1'b0;
      end
      chk("idle", {6'h00, xfer_active_out, cache_busy_out | live_wvalid_out}, 8'h00);
      stall <= 1'b0;
      repeat (4) @(negedge clk_in);
   endtask

   // ======================================
   // Transfers
   task automatic do_write(input logic [7:0] p, input int n);
      logic a;
      logic [7:0] d;
      m.start();
      m.wr_byte(i2c_pkg::ADDR_WR, a);
      chk("ack wr", {7'h00, a}, 8'h01);
      m.wr_byte(p, a);
      chk("ack ptr", {7'h00, a}, 8'h01);
      ptr = p;
      repeat (n) begin
         d = 8'($urandom);
         m.wr_byte(d, a);
         chk("ack data", {7'h00, a}, 8'h01);
         exp_mem[ptr] = d;
         ptr = nxt(ptr);
      end
      m.stop();
      settle();
      for (int i = 0; i < 256; i++) begin
         chk("live", live_mem[i], exp_mem[i]);
      end
   endtask

   task automatic do_read(input int n);
      logic a;
      logic hit;
      logic [7:0] d;
      m.start();
      m.wr_byte(i2c_pkg::ADDR_RD, a);
      chk("ack rd", {7'h00, a}, 8'h01);
      chk("active rd", {7'h00, xfer_active_out}, 8'h01);
      hit = ptr[7:3] >= i2c_pkg::CPAGE_LO && ptr[7:3] <= i2c_pkg::CPAGE_HI;
      // Live words of a cached page move after the snapshot was taken
      for (int i = 0; i < 8; i++) begin
         snap[i] = exp_mem[{ptr[7:3], 3'(i)}];
         if (hit) begin
            exp_mem[{ptr[7:3], 3'(i)}] = 8'($urandom);
            live_mem[{ptr[7:3], 3'(i)}] = exp_mem[{ptr[7:3], 3'(i)}];
         end
      end
      for (int k = 1; k <= n; k++) begin
         m.rd_byte(k < n, d);
         chk("rd data", d, snap[ptr[2:0]]);
         if (k < n) ptr = nxt(ptr);
      end
      m.stop();
      settle();
   endtask

   task automatic do_foreign(input logic [7:0] adr);
      logic a;
      m.start();
      m.wr_byte(adr, a);
      chk("ack foreign", {7'h00, a}, 8'h00);
      chk("active foreign", {7'h00, xfer_active_out}, 8'h00);
      m.wr_byte(8'h00, a);
      chk("ack ignored", {7'h00, a}, 8'h00);
      m.stop();
      settle();
   endtask

   // ======================================
   // Main sequence
   initial begin
      // Late enough that the asynchronous reset is seen before the first edge
      #1 rstn_in = 1'b0;
      void'($urandom(54143));
      ptr = i2c_pkg::PTR_RST;
      for (int i = 0; i < 256; i++) begin
         live_mem[i] = 8'($urandom);
         exp_mem[i] = live_mem[i];
      end
      repeat (6) @(negedge clk_in);
      rstn_in = 1'b1;
      repeat (4) @(negedge clk_in);
      do_read(2);
      do_write(8'h0E, 3);
      do_read(2);
      do_write(8'h0E, 0);
      do_read(4);
      do_read(1);
      for (int i = 1; i < 8; i++) begin
         do_foreign(i2c_pkg::ADDR_WR ^ (8'h01 << i));
      end
      stall = 1'b1;
      do_write(8'h20, 8);
      for (int t = 0; t < 10; t++) begin
         do_write(8'($urandom), $urandom_range(0, 9));
         do_read($urandom_range(1, 10));
      end
      test_done();
   end

   initial begin
      #200000;
      fails++;
      test_done();
   end
endmodule
